// [inc/ttg_pkg.sv]
package ttg_pkg;

  // arbitration states, one-hot
  typedef enum logic [4:0] {
    TTG_ST_IDLE = 5'h01,
    TTG_ST_REQ  = 5'h02,
    TTG_ST_GNTD = 5'h04,
    TTG_ST_SEND = 5'h08,
    TTG_ST_GAP  = 5'h10
  } ttg_state_t;

  // transmit sideband word, bit 3 down to bit 0
  typedef struct packed {
    logic discontinue;
    logic streamed;
    logic err_fwd;
    logic ecrc_gen;
  } ttg_tuser_t;

  // per-packet flags reported the cycle after the end beat
  typedef struct packed {
    logic poison;
    logic ecrc;
    logic streamed;
  } ttg_flags_t;

  localparam ttg_flags_t TTG_FLAGS_RST = 3'h0;
  localparam logic [1:0] TTG_RST_SYNC_RST = 2'h0;

endpackage

// [rtl/ttg_grant_flags.sv]
`timescale 1ns/10ps
// Overview of operation
// - Request drops after each internal packet is serviced, before any new request.
// - Without a grant, user packets keep priority over the pending internal packet.
// - A one-cycle grant during request makes the internal packet go next.
// - Without buffer space, request stays high and the grant is remembered.
// - Poison bit on any beat, start through end, poisons the packet.
// - Digest bit on the first beat appends an end-to-end CRC digest.
// - Request rises when the core has an internal packet ready.
module ttg_grant_flags
  import ttg_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // core internal packet source
  input  wire logic       int_pkt_ready,
  input  wire logic       int_buf_avail,
  input  wire logic       int_pkt_done,
  output logic            int_send_start,
  // grant handshake with user logic
  output logic            tx_cfg_req,
  input  wire logic       tx_cfg_gnt,
  // transmit stream beats
  input  wire logic       s_axis_tx_tvalid,
  input  wire logic       s_axis_tx_tready,
  input  wire logic       s_axis_tx_tlast,
  input  wire ttg_tuser_t s_axis_tx_tuser,
  // arbitration and packet flags
  output logic            user_start_ok,
  output ttg_flags_t      pkt_flags,
  output logic            pkt_flags_valid,
  output logic            poison_stream_err
);

  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_r <= TTG_RST_SYNC_RST;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // beat tracking
  logic beat;
  logic sof;
  logic in_pkt_r;
  logic in_pkt_nxt;

  assign beat = s_axis_tx_tvalid && s_axis_tx_tready;
  assign sof  = beat && !in_pkt_r;

  always_comb begin
    in_pkt_nxt = in_pkt_r;
    if (beat) begin
      in_pkt_nxt = !s_axis_tx_tlast;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_pkt_r <= 1'b0;
    end else begin
      in_pkt_r <= in_pkt_nxt;
    end
  end

  // grant arbitration
  ttg_state_t state_r;
  ttg_state_t state_nxt;
  logic       req_r;
  logic       req_nxt;
  logic       start_r;
  logic       start_nxt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TTG_ST_IDLE: begin
        if (int_pkt_ready) begin
          state_nxt = TTG_ST_REQ;
        end
      end
      TTG_ST_REQ: begin
        if (tx_cfg_gnt) begin
          if (int_buf_avail && !in_pkt_nxt) begin
            state_nxt = TTG_ST_SEND;
          end else begin
            state_nxt = TTG_ST_GNTD;
          end
        end
      end
      TTG_ST_GNTD: begin
        if (int_buf_avail && !in_pkt_nxt) begin
          state_nxt = TTG_ST_SEND;
        end
      end
      TTG_ST_SEND: begin
        if (int_pkt_done) begin
          state_nxt = TTG_ST_GAP;
        end
      end
      TTG_ST_GAP: begin
        state_nxt = TTG_ST_IDLE;
      end
      default: begin
        state_nxt = TTG_ST_IDLE;
      end
    endcase
    req_nxt   = (state_nxt == TTG_ST_REQ) || (state_nxt == TTG_ST_GNTD);
    start_nxt = (state_nxt == TTG_ST_SEND) && (state_r != TTG_ST_SEND);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TTG_ST_IDLE;
      req_r   <= 1'b0;
      start_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r   <= req_nxt;
      start_r <= start_nxt;
    end
  end

  assign tx_cfg_req     = req_r;
  assign int_send_start = start_r;
  // user packets may start unless the internal packet holds the slot
  assign user_start_ok  = (state_r != TTG_ST_GNTD) && (state_r != TTG_ST_SEND);

  // per-packet sideband flags
  logic       poison_r;
  logic       ecrc_r;
  logic       stream_r;
  logic       poison_cur;
  logic       ecrc_cur;
  logic       stream_cur;
  ttg_flags_t flags_r;
  ttg_flags_t flags_nxt;
  logic       flags_vld_r;
  logic       flags_vld_nxt;
  logic       perr_r;
  logic       perr_nxt;

  always_comb begin
    poison_cur = poison_r;
    ecrc_cur   = ecrc_r;
    stream_cur = stream_r;
    if (sof) begin
      poison_cur = s_axis_tx_tuser.err_fwd;
      ecrc_cur   = s_axis_tx_tuser.ecrc_gen;
      stream_cur = s_axis_tx_tuser.streamed;
    end else if (beat) begin
      poison_cur = poison_r || s_axis_tx_tuser.err_fwd;
    end
    flags_nxt     = flags_r;
    flags_vld_nxt = beat && s_axis_tx_tlast;
    if (beat && s_axis_tx_tlast) begin
      flags_nxt = '{poison: poison_cur, ecrc: ecrc_cur, streamed: stream_cur};
    end
    // poisoning a cut-through packet is a user fault, flagged for one cycle
    perr_nxt = beat && s_axis_tx_tuser.err_fwd && stream_cur;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      poison_r    <= 1'b0;
      ecrc_r      <= 1'b0;
      stream_r    <= 1'b0;
      flags_r     <= TTG_FLAGS_RST;
      flags_vld_r <= 1'b0;
      perr_r      <= 1'b0;
    end else begin
      poison_r    <= poison_cur;
      ecrc_r      <= ecrc_cur;
      stream_r    <= stream_cur;
      flags_r     <= flags_nxt;
      flags_vld_r <= flags_vld_nxt;
      perr_r      <= perr_nxt;
    end
  end

  assign pkt_flags         = flags_r;
  assign pkt_flags_valid   = flags_vld_r;
  assign poison_stream_err = perr_r;

  property p_req_drop;
    @(posedge clk) disable iff (!rst_n)
      (state_r == TTG_ST_SEND && int_pkt_done) |=> (!tx_cfg_req) [*2];
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request not dropped after service");

  property p_req_rise;
    @(posedge clk) disable iff (!rst_n)
      (state_r == TTG_ST_IDLE && int_pkt_ready) |=> tx_cfg_req;
  endproperty
  a_req_rise: assert property (p_req_rise) else $error("request not raised for ready packet");

  property p_user_prio;
    @(posedge clk) disable iff (!rst_n)
      (state_r == TTG_ST_REQ && !tx_cfg_gnt) |-> user_start_ok ##1 !int_send_start;
  endproperty
  a_user_prio: assert property (p_user_prio) else $error("internal packet sent without grant");

  property p_grant_next;
    @(posedge clk) disable iff (!rst_n)
      (state_r == TTG_ST_REQ && tx_cfg_gnt && int_buf_avail && !in_pkt_nxt) |=> int_send_start && !tx_cfg_req;
  endproperty
  a_grant_next: assert property (p_grant_next) else $error("grant did not start internal packet");

  property p_grant_held;
    @(posedge clk) disable iff (!rst_n)
      (state_r == TTG_ST_REQ && tx_cfg_gnt && !int_buf_avail) ##1 (!int_buf_avail && !tx_cfg_gnt)
        |=> tx_cfg_req && state_r == TTG_ST_GNTD;
  endproperty
  a_grant_held: assert property (p_grant_held) else $error("captured grant lost");

  property p_grant_ignored;
    @(posedge clk) disable iff (!rst_n)
      ((state_r == TTG_ST_IDLE || state_r == TTG_ST_GAP) && tx_cfg_gnt) |=> !int_send_start;
  endproperty
  a_grant_ignored: assert property (p_grant_ignored) else $error("stray grant started a packet");

  property p_poison;
    @(posedge clk) disable iff (!rst_n)
      (beat && s_axis_tx_tlast && (s_axis_tx_tuser.err_fwd || (in_pkt_r && poison_r)))
        |=> pkt_flags_valid && pkt_flags.poison;
  endproperty
  a_poison: assert property (p_poison) else $error("poison mark not reported");

  // digest request taken at the first beat of a longer packet
  property p_ecrc;
    @(posedge clk) disable iff (!rst_n)
      (sof && !s_axis_tx_tlast && s_axis_tx_tuser.ecrc_gen) |=> ecrc_r;
  endproperty
  a_ecrc: assert property (p_ecrc) else $error("digest request lost");

  // held digest request reaches the end-of-packet report
  property p_ecrc_end;
    @(posedge clk) disable iff (!rst_n)
      (beat && s_axis_tx_tlast && in_pkt_r && ecrc_r) |=> pkt_flags_valid && pkt_flags.ecrc;
  endproperty
  a_ecrc_end: assert property (p_ecrc_end) else $error("digest not reported at packet end");

  // single-beat packet carries its digest request straight to the report
  property p_ecrc_single;
    @(posedge clk) disable iff (!rst_n)
      (sof && s_axis_tx_tlast && s_axis_tx_tuser.ecrc_gen) |=> pkt_flags_valid && pkt_flags.ecrc;
  endproperty
  a_ecrc_single: assert property (p_ecrc_single) else $error("single-beat digest lost");

endmodule

// [verification/ttg_user_model.sv]
`timescale 1ns/10ps
module ttg_user_model (
  // clock
  input  wire logic       clk,
  // grant handshake
  input  wire logic       tx_cfg_req,
  input  wire logic [1:0] gnt_mode,
  output logic            tx_cfg_gnt
);
  logic req_r;

  // mode 0 withholds, 1 pulses on a new request, 2 holds high
  always @(posedge clk) begin
    req_r      <= tx_cfg_req;
    tx_cfg_gnt <= (gnt_mode == 2'h2) || (gnt_mode == 2'h1 && tx_cfg_req && !req_r);
  end
endmodule

// [verification/tb_ttg_grant_flags.sv]
`timescale 1ns/10ps
module tb_ttg_grant_flags
  import ttg_pkg::*;
();
  logic       clk, rst_b, rdy, buf_ok, done, tvalid, tready, tlast;
  logic       start, req, gnt, ok, fv, perr, seen;
  logic [1:0] mode;
  ttg_tuser_t tuser;
  ttg_flags_t flags;
  int         n_errors, comparisons, cycles, n;

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ttg_grant_flags DUT (.clk(clk), .rst_b(rst_b), .int_pkt_ready(rdy), .int_buf_avail(buf_ok),
    .int_pkt_done(done), .int_send_start(start), .tx_cfg_req(req), .tx_cfg_gnt(gnt),
    .s_axis_tx_tvalid(tvalid), .s_axis_tx_tready(tready), .s_axis_tx_tlast(tlast),
    .s_axis_tx_tuser(tuser), .user_start_ok(ok), .pkt_flags(flags), .pkt_flags_valid(fv),
    .poison_stream_err(perr));
  ttg_user_model u_user (.clk(clk), .tx_cfg_req(req), .gnt_mode(mode), .tx_cfg_gnt(gnt));

  task chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: bit got %b exp %b", $time, got, exp);
    end
  endtask

  task chk_flags(input ttg_flags_t got, input ttg_flags_t exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: flags got %h exp %h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task beat(input ttg_tuser_t u, input logic l);
    @(posedge clk);
    tvalid <= 1'b1;
    tuser  <= u;
    tlast  <= l;
  endtask

  // idle sideband is junk on purpose
  task pkt(input logic two, input ttg_tuser_t a, input ttg_tuser_t b, input ttg_flags_t exp);
    if (two)
      beat(a, 1'b0);
    beat(b, 1'b1);
    @(posedge clk);
    tvalid <= 1'b0;
    tuser  <= 4'hF;
    #1;
    chk_bit(fv, 1'b1);
    chk_flags(flags, exp);
  endtask

  task wait_start(input int cnt, input logic exp);
    seen = 1'b0;
    repeat (cnt) begin
      @(posedge clk);
      #1;
      if (start === 1'b1) begin
        seen = 1'b1;
        chk_bit(req, 1'b0);
        chk_bit(ok, 1'b0);
      end
    end
    chk_bit(seen, exp);
  endtask

  task finish_int(input logic keep);
    @(posedge clk);
    rdy  <= keep;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      conclude;
    end
  end

  initial begin
    rst_b = 1'b0;
    rdy = 1'b0;
    buf_ok = 1'b1;
    done = 1'b0;
    tvalid = 1'b0;
    tready = 1'b1;
    tlast = 1'b0;
    tuser = 4'h0;
    mode = 2'h1;
    n_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_bit(req, 1'b0);
    chk_bit(ok, 1'b1);
    pkt(1'b1, 4'h1, 4'h2, 3'h6);
    pkt(1'b1, 4'h4, 4'h1, 3'h1);
    chk_bit(perr, 1'b0);
    // deliberate user fault to exercise the cut-through poison detector
    pkt(1'b1, 4'h4, 4'h2, 3'h5);
    chk_bit(perr, 1'b1);
    pkt(1'b0, 4'h0, 4'h2, 3'h4);
    @(posedge clk);
    rdy <= 1'b1;
    wait_start(6, 1'b1);
    finish_int(1'b1);
    #1;
    chk_bit(req, 1'b0);
    @(posedge clk);
    #1;
    chk_bit(req, 1'b0);
    n = 0;
    while (req !== 1'b1 && n < 6) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(req, 1'b1);
    wait_start(6, 1'b1);
    finish_int(1'b0);
    @(posedge clk);
    buf_ok <= 1'b0;
    rdy    <= 1'b1;
    wait_start(8, 1'b0);
    chk_bit(req, 1'b1);
    @(posedge clk);
    buf_ok <= 1'b1;
    wait_start(3, 1'b1);
    finish_int(1'b0);
    @(posedge clk);
    mode <= 2'h0;
    rdy  <= 1'b1;
    pkt(1'b1, 4'h0, 4'h0, 3'h0);
    wait_start(6, 1'b0);
    chk_bit(req, 1'b1);
    chk_bit(ok, 1'b1);
    @(posedge clk);
    mode <= 2'h2;
    wait_start(4, 1'b1);
    finish_int(1'b0);
    wait_start(8, 1'b0);
    chk_bit(req, 1'b0);
    conclude;
  end
endmodule
